// >>> rtl/dcr_config_regs.sv
// configuration registers 0x13..0x19 with routing, sync, offset and power controls
// Function
// - copy bit set: channel A sample stream also drives channel B.
// - copy bit set: channel B sample stream also drives channel A.
// - sync select: 0 external strobe, 1 frame via FIFO; both sync uses.
// - flip bit set: input data word bit order reversed, MSB becomes LSB.
// - channel A offset is 13 bits: low byte 0x14, high five bits 0x16[7:3].
// - channel B offset is 13 bits: low byte 0x15, high five bits 0x17[7:3].
// - write to 0x14 loads all four offset bytes at once; others wait.
// - four-wire bit set: alarm pin becomes dedicated serial read-data output.
// - 0x17 bits 1 and 0 sleep clock paths of channel A and B.
// - temperature sensor enable powers sensor, resets to one.
// - 0x18 bit 6 sleeps clock receiver and external strobe receiver.
// - 0x18 bits 3 and 2 sleep converter B and converter A.
// - 0x19 bit 2 chooses reference: 0 internal, 1 external.
// - divider sync enable uses chosen sync source; meant for initialization.
module dcr_config_regs
    import dcr_pkg::*;
#(
    parameter int SAMPLE_W = 16,
    parameter int WORD_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port from the serial interface decoder
    input wire dcr_access_type reg_access,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // sample streams
    input wire logic [SAMPLE_W-1:0] sample_a_in,
    input wire logic [SAMPLE_W-1:0] sample_b_in,
    output logic [SAMPLE_W-1:0] sample_a_out,
    output logic [SAMPLE_W-1:0] sample_b_out,
    // input data word
    input wire logic [WORD_W-1:0] data_word_in,
    output logic [WORD_W-1:0] data_word_out,
    // sync sources and results
    input wire logic external_sync_strobe,
    input wire logic frame_sync,
    input wire logic clkdiv_sync_enable,
    output logic multi_device_sync,
    output logic clkdiv_sync,
    // active offset correction
    output dcr_offset_type offset_active,
    // serial pin mode
    input wire logic alarm_in,
    input wire logic serial_read_data,
    output logic four_wire_serial_select,
    output logic alarm_pin_out,
    // power and reference controls
    output logic clkpath_sleep_a,
    output logic clkpath_sleep_b,
    output logic tsense_enable,
    output logic clkrecv_sleep,
    output logic converter_sleep_a,
    output logic converter_sleep_b,
    output logic external_ref_select
);

    // refused at elaboration: a zero-width lane has nothing to route or reverse
    if (SAMPLE_W < 1 || WORD_W < 1) begin : g_width_check
        $error("dcr_config_regs: widths must be at least one");
    end

    logic [7:0] route_sync_r;
    logic [7:0] offa_low_r;
    logic [7:0] offb_low_r;
    logic [7:0] offa_high_r;
    logic [7:0] offb_high_ser_r;
    logic [7:0] power_sense_r;
    logic [7:0] ref_select_r;
    logic autosync;
    logic [WORD_W-1:0] flipped_word;
    logic strobe_live;
    logic sync_source;
    dcr_offset_type offset_nxt;

    // ---------------- register writes ----------------
    always_ff @(posedge clk) begin
        if (reset) begin
            route_sync_r <= RST_ROUTE_SYNC;
        end else if (reg_access.wr && reg_access.addr == ADDR_ROUTE_SYNC) begin
            route_sync_r <= reg_access.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            offa_low_r <= RST_OFFA_LOW;
        end else if (autosync) begin
            offa_low_r <= reg_access.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            offb_low_r <= RST_OFFB_LOW;
        end else if (reg_access.wr && reg_access.addr == ADDR_OFFB_LOW) begin
            offb_low_r <= reg_access.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            offa_high_r <= RST_OFFA_HIGH;
        end else if (reg_access.wr && reg_access.addr == ADDR_OFFA_HIGH) begin
            offa_high_r <= reg_access.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            offb_high_ser_r <= RST_OFFB_HIGH_SER;
        end else if (reg_access.wr && reg_access.addr == ADDR_OFFB_HIGH_SER) begin
            offb_high_ser_r <= reg_access.wdata;
        end
    end

    // reserved bits are stored as written, so a host that keeps them at default reads them back
    always_ff @(posedge clk) begin
        if (reset) begin
            power_sense_r <= RST_POWER_SENSE;
        end else if (reg_access.wr && reg_access.addr == ADDR_POWER_SENSE) begin
            power_sense_r <= reg_access.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ref_select_r <= RST_REF_SELECT;
        end else if (reg_access.wr && reg_access.addr == ADDR_REF_SELECT) begin
            ref_select_r <= reg_access.wdata;
        end
    end

    // ---------------- readback ----------------
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= READ_UNMAPPED;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_access.rd;
            if (reg_access.rd) begin
                case (reg_access.addr)
                    ADDR_ROUTE_SYNC: reg_rdata <= route_sync_r;
                    ADDR_OFFA_LOW: reg_rdata <= offa_low_r;
                    ADDR_OFFB_LOW: reg_rdata <= offb_low_r;
                    ADDR_OFFA_HIGH: reg_rdata <= offa_high_r;
                    ADDR_OFFB_HIGH_SER: reg_rdata <= offb_high_ser_r;
                    ADDR_POWER_SENSE: reg_rdata <= power_sense_r;
                    ADDR_REF_SELECT: reg_rdata <= ref_select_r;
                    default: reg_rdata <= READ_UNMAPPED;
                endcase
            end
        end
    end

    // ---------------- offset autosync ----------------
    assign autosync = reg_access.wr && reg_access.addr == ADDR_OFFA_LOW;

    // the new low byte comes from the write itself so it joins the same load
    always_comb begin
        offset_nxt.a = {offa_high_r[OFF_HIGH_MSB:OFF_HIGH_LSB], reg_access.wdata};
        offset_nxt.b = {offb_high_ser_r[OFF_HIGH_MSB:OFF_HIGH_LSB], offb_low_r};
    end

    // staged bytes stay invisible until the low A byte lands, so a partial update never glitches
    always_ff @(posedge clk) begin
        if (reset) begin
            offset_active <= '0;
        end else if (autosync) begin
            offset_active <= offset_nxt;
        end
    end

    // ---------------- sample routing ----------------
    // with both copy bits set the channels simply swap
    always_ff @(posedge clk) begin
        if (reset) begin
            sample_a_out <= '0;
            sample_b_out <= '0;
        end else begin
            sample_a_out <= route_sync_r[BIT_COPY_B_TO_A] ? sample_b_in : sample_a_in;
            sample_b_out <= route_sync_r[BIT_COPY_A_TO_B] ? sample_a_in : sample_b_in;
        end
    end

    // ---------------- bit-order flip ----------------
    always_comb begin
        for (int i = 0; i < WORD_W; i++) begin
            flipped_word[i] = data_word_in[WORD_W-1-i];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            data_word_out <= '0;
        end else begin
            data_word_out <= route_sync_r[BIT_BIT_FLIP] ? flipped_word : data_word_in;
        end
    end

    // ---------------- sync source ----------------
    // a sleeping clock receiver also silences the strobe receiver
    assign strobe_live = external_sync_strobe && !power_sense_r[BIT_CLKRECV_SLEEP];
    assign sync_source = (route_sync_r[BIT_SYNC_SEL] == SYNC_SRC_FRAME) ? frame_sync
                                                                        : strobe_live;

    // divider sync is left to the host to disable after initialization
    always_ff @(posedge clk) begin
        if (reset) begin
            multi_device_sync <= 1'b0;
            clkdiv_sync <= 1'b0;
        end else begin
            multi_device_sync <= sync_source;
            clkdiv_sync <= sync_source && clkdiv_sync_enable;
        end
    end

    // ---------------- serial pin mode ----------------
    always_ff @(posedge clk) begin
        if (reset) begin
            alarm_pin_out <= 1'b0;
        end else begin
            alarm_pin_out <= offb_high_ser_r[BIT_FOUR_WIRE] ? serial_read_data : alarm_in;
        end
    end

    // ---------------- static controls straight from register bits ----------------
    assign four_wire_serial_select = offb_high_ser_r[BIT_FOUR_WIRE];
    assign clkpath_sleep_a = offb_high_ser_r[BIT_CLKPATH_SLEEP_A];
    assign clkpath_sleep_b = offb_high_ser_r[BIT_CLKPATH_SLEEP_B];
    assign tsense_enable = power_sense_r[BIT_TSENSE_ENA];
    assign clkrecv_sleep = power_sense_r[BIT_CLKRECV_SLEEP];
    assign converter_sleep_a = power_sense_r[BIT_SLEEP_A];
    assign converter_sleep_b = power_sense_r[BIT_SLEEP_B];
    assign external_ref_select = ref_select_r[BIT_EXT_REF];

    // ---------------- assertions ----------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_write_offa_low;
        reg_access.wr && reg_access.addr == ADDR_OFFA_LOW;
    endsequence

    sequence s_write_other_offset;
        reg_access.wr && (reg_access.addr == ADDR_OFFB_LOW || reg_access.addr == ADDR_OFFA_HIGH
                          || reg_access.addr == ADDR_OFFB_HIGH_SER);
    endsequence

    sequence s_write_power;
        reg_access.wr && reg_access.addr == ADDR_POWER_SENSE;
    endsequence

    a_copy_a_to_b: assert property (
        route_sync_r[BIT_COPY_A_TO_B] |=> sample_b_out == $past(sample_a_in))
        else $error("channel B does not carry channel A samples");

    a_copy_b_to_a: assert property (
        route_sync_r[BIT_COPY_B_TO_A] |=> sample_a_out == $past(sample_b_in))
        else $error("channel A does not carry channel B samples");

    a_no_copy_pass: assert property (
        !route_sync_r[BIT_COPY_A_TO_B] && !route_sync_r[BIT_COPY_B_TO_A]
        |=> sample_a_out == $past(sample_a_in) && sample_b_out == $past(sample_b_in))
        else $error("samples altered with copying off");

    a_sync_frame_src: assert property (
        route_sync_r[BIT_SYNC_SEL] |=> multi_device_sync == $past(frame_sync))
        else $error("frame source not followed");

    a_sync_strobe_src: assert property (
        !route_sync_r[BIT_SYNC_SEL] && power_sense_r[BIT_CLKRECV_SLEEP] |=> !multi_device_sync)
        else $error("strobe passed while receiver sleeps");

    a_sync_strobe_pass: assert property (
        !route_sync_r[BIT_SYNC_SEL] && !power_sense_r[BIT_CLKRECV_SLEEP]
        |=> multi_device_sync == $past(external_sync_strobe))
        else $error("strobe source not followed");

    a_bit_flip: assert property (
        route_sync_r[BIT_BIT_FLIP] |=> data_word_out[0] == $past(data_word_in[WORD_W-1]))
        else $error("data word not reversed");

    a_autosync_load: assert property (
        s_write_offa_low |=> offset_active.a[7:0] == $past(reg_access.wdata)
                             && offset_active.b[7:0] == $past(offb_low_r))
        else $error("autosync did not load offsets");

    a_offset_hold: assert property (
        s_write_other_offset |=> $stable(offset_active))
        else $error("active offset changed without autosync");

    a_offset_high: assert property (
        s_write_offa_low |=> offset_active.a[OFFSET_W-1:8] == $past(offa_high_r[7:3]))
        else $error("channel A high offset bits wrong");

    a_offset_b_high: assert property (
        s_write_offa_low |=> offset_active.b[OFFSET_W-1:8] == $past(offb_high_ser_r[7:3]))
        else $error("channel B high offset bits wrong");

    a_alarm_pin_mode: assert property (
        four_wire_serial_select && $stable(four_wire_serial_select)
        |=> alarm_pin_out == $past(serial_read_data))
        else $error("alarm pin not carrying read data in four-wire mode");

    a_alarm_pin_alarm: assert property (
        !four_wire_serial_select && $stable(four_wire_serial_select)
        |=> alarm_pin_out == $past(alarm_in))
        else $error("alarm pin not carrying alarm in three-wire mode");

    a_divider_sync: assert property (
        !clkdiv_sync_enable |=> !clkdiv_sync)
        else $error("divider sync without enable");

    a_divider_follow: assert property (
        clkdiv_sync_enable |=> clkdiv_sync == multi_device_sync)
        else $error("divider sync not following the chosen source");

    a_tsense_write: assert property (
        s_write_power |=> tsense_enable == $past(reg_access.wdata[BIT_TSENSE_ENA]))
        else $error("temperature sensor enable not written");

    a_recv_sleep_write: assert property (
        s_write_power |=> clkrecv_sleep == $past(reg_access.wdata[BIT_CLKRECV_SLEEP]))
        else $error("clock receiver sleep not written");

    a_dac_sleep_write: assert property (
        s_write_power |=> {converter_sleep_b, converter_sleep_a}
                          == $past(reg_access.wdata[BIT_SLEEP_B:BIT_SLEEP_A]))
        else $error("converter sleep bits not written");

    a_clkpath_write: assert property (
        reg_access.wr && reg_access.addr == ADDR_OFFB_HIGH_SER
        |=> {clkpath_sleep_a, clkpath_sleep_b}
            == $past(reg_access.wdata[BIT_CLKPATH_SLEEP_A:BIT_CLKPATH_SLEEP_B]))
        else $error("clock path sleep bits not written");

    a_ref_write: assert property (
        reg_access.wr && reg_access.addr == ADDR_REF_SELECT
        |=> external_ref_select == $past(reg_access.wdata[BIT_EXT_REF]))
        else $error("reference select not written");

    a_tsense_reset: assert property (
        $fell(reset) |-> tsense_enable)
        else $error("temperature sensor not on after reset");

endmodule

// >>> rtl/dcr_pkg.sv
// package: offsets, fields, resets and carriers for configuration registers 0x13..0x19
package dcr_pkg;

    // register addresses on the serial control register port
    localparam logic [7:0] ADDR_ROUTE_SYNC = 8'h13;
    localparam logic [7:0] ADDR_OFFA_LOW = 8'h14;
    localparam logic [7:0] ADDR_OFFB_LOW = 8'h15;
    localparam logic [7:0] ADDR_OFFA_HIGH = 8'h16;
    localparam logic [7:0] ADDR_OFFB_HIGH_SER = 8'h17;
    localparam logic [7:0] ADDR_POWER_SENSE = 8'h18;
    localparam logic [7:0] ADDR_REF_SELECT = 8'h19;

    // reset values
    localparam logic [7:0] RST_ROUTE_SYNC = 8'h00;
    localparam logic [7:0] RST_OFFA_LOW = 8'h00;
    localparam logic [7:0] RST_OFFB_LOW = 8'h00;
    localparam logic [7:0] RST_OFFA_HIGH = 8'h00;
    localparam logic [7:0] RST_OFFB_HIGH_SER = 8'h00;
    localparam logic [7:0] RST_POWER_SENSE = 8'h83;
    localparam logic [7:0] RST_REF_SELECT = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // field positions in channel_routing_sync_select
    localparam int BIT_COPY_A_TO_B = 7;
    localparam int BIT_COPY_B_TO_A = 6;
    localparam int BIT_SYNC_SEL = 1;
    localparam int BIT_BIT_FLIP = 0;

    // offset high fields in 0x16 / 0x17
    localparam int OFF_HIGH_MSB = 7;
    localparam int OFF_HIGH_LSB = 3;
    localparam int OFFSET_W = 13;

    // serial and clock-path fields in 0x17
    localparam int BIT_FOUR_WIRE = 2;
    localparam int BIT_CLKPATH_SLEEP_A = 1;
    localparam int BIT_CLKPATH_SLEEP_B = 0;

    // power_sensor_control fields
    localparam int BIT_TSENSE_ENA = 7;
    localparam int BIT_CLKRECV_SLEEP = 6;
    localparam int BIT_SLEEP_B = 3;
    localparam int BIT_SLEEP_A = 2;

    // reference_select field
    localparam int BIT_EXT_REF = 2;

    // sync source encodings
    localparam logic SYNC_SRC_STROBE = 1'b0;
    localparam logic SYNC_SRC_FRAME = 1'b1;

    // one register access from the serial interface decoder
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dcr_access_type;

    // active offset pair handed to the correction logic
    typedef struct packed {
        logic [OFFSET_W-1:0] a;
        logic [OFFSET_W-1:0] b;
    } dcr_offset_type;

endpackage

// >>> tb/dcr_host_model.sv
// host model: drives the register port the way the serial decoder would
module dcr_host_model
    import dcr_pkg::*;
(
    // clock
    input wire logic clk,
    // register port
    output dcr_access_type reg_access,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        reg_access = '0;
    end

    // idle address and data show the inverse of the last value, never a stale match
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk);
        reg_access <= {1'b1, 1'b0, addr, data};
        @(negedge clk);
        reg_access <= {2'b00, ~addr, ~data};
    endtask

    // read valid stands for one cycle after the taking edge; read data holds until the next read
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data,
                            output logic valid);
        @(negedge clk);
        reg_access <= {1'b0, 1'b1, addr, 8'h00};
        @(negedge clk);
        reg_access <= {2'b00, ~addr, 8'hFF};
        data = reg_rdata;
        valid = reg_rvalid;
    endtask
endmodule

// >>> tb/tb.sv
// self-checking bench for configuration registers 0x13..0x19
module tb import dcr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk, reset;
    dcr_access_type reg_access;
    logic [7:0] reg_rdata, data_word_in, data_word_out, cfg13, cfg17, cfg18, cfg19, a, d, rdv;
    logic reg_rvalid, vld, external_sync_strobe, frame_sync, clkdiv_sync_enable;
    logic multi_device_sync, clkdiv_sync, alarm_in, serial_read_data, four_wire_serial_select;
    logic alarm_pin_out, clkpath_sleep_a, clkpath_sleep_b, tsense_enable, clkrecv_sleep;
    logic converter_sleep_a, converter_sleep_b, external_ref_select;
    logic [15:0] sample_a_in, sample_b_in, sample_a_out, sample_b_out;
    dcr_offset_type offset_active, off_exp;
    logic [31:0] seed, r;
    int failures = 0;
    int n_checks = 0;
    int cycles = 0;

    dcr_config_regs dcr_config_regs_i (.clk(clk), .reset(reset), .reg_access(reg_access),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sample_a_in(sample_a_in),
        .sample_b_in(sample_b_in), .sample_a_out(sample_a_out), .sample_b_out(sample_b_out),
        .data_word_in(data_word_in), .data_word_out(data_word_out),
        .external_sync_strobe(external_sync_strobe), .frame_sync(frame_sync),
        .clkdiv_sync_enable(clkdiv_sync_enable), .multi_device_sync(multi_device_sync),
        .clkdiv_sync(clkdiv_sync), .offset_active(offset_active), .alarm_in(alarm_in),
        .serial_read_data(serial_read_data), .four_wire_serial_select(four_wire_serial_select),
        .alarm_pin_out(alarm_pin_out), .clkpath_sleep_a(clkpath_sleep_a),
        .clkpath_sleep_b(clkpath_sleep_b), .tsense_enable(tsense_enable),
        .clkrecv_sleep(clkrecv_sleep), .converter_sleep_a(converter_sleep_a),
        .converter_sleep_b(converter_sleep_b), .external_ref_select(external_ref_select));

    dcr_host_model dcr_host_model_i (.clk(clk), .reg_access(reg_access),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    function automatic logic [7:0] rev8(input logic [7:0] x);
        logic [7:0] y;
        for (int k = 0; k < 8; k++) y[k] = x[7-k];
        return y;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // one sample through the datapath with the current configuration
    task automatic step_data();
        logic [15:0] ea, eb;
        logic src;
        r = rnd();
        sample_a_in = r[15:0];
        sample_b_in = r[31:16];
        r = rnd();
        data_word_in = r[7:0];
        {external_sync_strobe, frame_sync, clkdiv_sync_enable} = r[10:8];
        {alarm_in, serial_read_data} = r[12:11];
        ea = cfg13[6] ? sample_b_in : sample_a_in;
        eb = cfg13[7] ? sample_a_in : sample_b_in;
        // strobe receiver asleep blocks the strobe source only
        src = cfg13[1] ? frame_sync : (external_sync_strobe & ~cfg18[6]);
        @(negedge clk);
        check(sample_a_out, ea);
        check(sample_b_out, eb);
        check(data_word_out, cfg13[0] ? rev8(data_word_in) : data_word_in);
        check({multi_device_sync, clkdiv_sync}, {src, src & clkdiv_sync_enable});
        check(alarm_pin_out, cfg17[2] ? serial_read_data : alarm_in);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            print_verdict();
        end
    end

    initial begin
        reset = 1'b1;
        seed = 32'h000148EE;
        {sample_a_in, sample_b_in, data_word_in} = '0;
        {external_sync_strobe, frame_sync, clkdiv_sync_enable, alarm_in} = 4'h0;
        serial_read_data = 1'b0;
        {cfg13, cfg17, cfg18, cfg19} = {8'h00, 8'h00, RST_POWER_SENSE, 8'h00};
        off_exp = '0;
        repeat (12) @(negedge clk);
        reset = 1'b0;
        check(tsense_enable, 1'b1);
        check(offset_active, off_exp);
        for (int i = 0; i < 8; i++) begin
            dcr_host_model_i.read_reg(8'h13 + i[7:0], rdv, vld);
            check(vld, 1'b1);
            check(rdv, (i == 5) ? RST_POWER_SENSE : 8'h00);
        end
        for (int n = 0; n < 16; n++) begin
            for (int i = 0; i < 4; i++) begin
                r = rnd();
                a = (i == 0) ? 8'h13 : 8'h16 + i[7:0];
                d = (n == 0) ? 8'hFF : r[7:0];
                if (a == 8'h18) d[1:0] = 2'h3;
                dcr_host_model_i.write_reg(a, d);
                case (a)
                    8'h13: cfg13 = d;
                    8'h17: cfg17 = d;
                    8'h18: cfg18 = d;
                    default: cfg19 = d;
                endcase
                dcr_host_model_i.read_reg(a, rdv, vld);
                check({vld, rdv}, {1'b1, d});
            end
            check({four_wire_serial_select, clkpath_sleep_a, clkpath_sleep_b}, cfg17[2:0]);
            check({tsense_enable, clkrecv_sleep}, cfg18[7:6]);
            check({converter_sleep_b, converter_sleep_a}, cfg18[3:2]);
            check(external_ref_select, cfg19[2]);
            step_data();
            step_data();
        end
        dcr_host_model_i.write_reg(8'h1A, 8'hA5);
        dcr_host_model_i.read_reg(8'h1A, rdv, vld);
        check(rdv, READ_UNMAPPED);
        for (int i = 0; i < 4; i++) begin
            r = (i == 3) ? 32'hFFFFFFFF : rnd();
            dcr_host_model_i.write_reg(ADDR_OFFB_LOW, r[20:13]);
            dcr_host_model_i.write_reg(ADDR_OFFA_HIGH, {r[12:8], r[28:26]});
            dcr_host_model_i.write_reg(ADDR_OFFB_HIGH_SER, {r[25:21], cfg17[2:0]});
            check(offset_active, off_exp);
            dcr_host_model_i.write_reg(ADDR_OFFA_LOW, r[7:0]);
            off_exp = {r[12:0], r[25:13]};
            check(offset_active, off_exp);
            step_data();
        end
        // reset again in mid-run: defaults must return over the programmed values
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        check({tsense_enable, clkrecv_sleep, four_wire_serial_select}, 3'b100);
        check(offset_active, 26'h0);
        dcr_host_model_i.read_reg(ADDR_POWER_SENSE, rdv, vld);
        check({vld, rdv}, {1'b1, RST_POWER_SENSE});
        print_verdict();
    end
endmodule
